// File: logic/scbu_pkg.sv
// Shared constants and the start-input latch of the start-condition branch unit.
package scbu_pkg;
   localparam int unsigned   SCBU_ADDR_W    = 10;
   localparam int unsigned   SCBU_NSTART    = 6;
   localparam int unsigned   SCBU_NJREG     = 4;
   localparam int unsigned   SCBU_OFF_W     = 5;
   localparam int unsigned   SCBU_OPC_MSB   = 15;
   localparam int unsigned   SCBU_OPC_LSB   = 11;
   localparam int unsigned   SCBU_SEL_MSB   = 10;
   localparam int unsigned   SCBU_SEL_LSB   = 5;
   localparam int unsigned   SCBU_OFF_MSB   = 4;
   localparam int unsigned   SCBU_OFF_LSB   = 0;
   localparam int unsigned   SCBU_JREG_MSB  = 1;
   localparam int unsigned   SCBU_JREG_LSB  = 0;
   localparam int unsigned   SCBU_PAD_MSB   = 4;
   localparam int unsigned   SCBU_PAD_LSB   = 2;
   localparam logic [4:0]    SCBU_OPC_FAR   = 5'h07;
   localparam logic [4:0]    SCBU_OPC_REL   = 5'h01;
   localparam logic [2:0]    SCBU_FAR_PAD   = 3'h0;
   localparam logic [9:0]    SCBU_PC_RST    = 10'h000;
   localparam logic [9:0]    SCBU_PC_STEP   = 10'h001;
   localparam logic [5:0]    SCBU_START_RST = 6'h00;

   typedef struct packed {
      logic [5:0] sync1;
      logic [5:0] sync2;
      logic [5:0] prev;
      logic [5:0] latched;
   } scbu_latch_st_t;

   typedef struct packed {
      logic [9:0] next_pc;
      logic       valid;
      logic       taken;
   } scbu_br_st_t;
endpackage : scbu_pkg

//////////////////////////////////////////////////////////////////////////////

`timescale 1ns/1ns
module scbu_start_latch
   import scbu_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [5:0] start_pin,
   input  wire logic [5:0] start_clear,
   output logic      [5:0] start_latched
);
   scbu_latch_st_t st_r;
   scbu_latch_st_t st_nxt;

   // Rising edges of the synchronised pins set a sticky bit; a set in the
   // same cycle as its clear wins so that no start is lost.
   always_comb
   begin
      st_nxt         = st_r;
      st_nxt.sync1   = start_pin;
      st_nxt.sync2   = st_r.sync1;
      st_nxt.prev    = st_r.sync2;
      st_nxt.latched = (st_r.latched & ~start_clear) |
                       (st_r.sync2 & ~st_r.prev);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r <= '{SCBU_START_RST, SCBU_START_RST,
                   SCBU_START_RST, SCBU_START_RST};
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign start_latched = st_r.latched;
endmodule : scbu_start_latch

// File: logic/scbu_branch.sv
// Start-condition branch unit: far and relative jumps on latched starts.
`timescale 1ns/1ns
module scbu_branch
   import scbu_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        instr_valid,
   input  wire logic [15:0] instr_word,
   input  wire logic [9:0]  instr_addr,
   input  wire logic [9:0]  jump_reg0,
   input  wire logic [9:0]  jump_reg1,
   input  wire logic [9:0]  jump_reg2,
   input  wire logic [9:0]  jump_reg3,
   input  wire logic [5:0]  start_pin,
   input  wire logic [5:0]  start_clear,
   output logic             is_branch,
   output logic [9:0]       program_counter,
   output logic             pc_valid,
   output logic             branch_taken,
   output logic [5:0]       start_latched
);
   scbu_br_st_t st_r;
   scbu_br_st_t st_nxt;

   logic [4:0]  opcode;
   logic [5:0]  start_selector;
   logic [1:0]  jump_reg_operand;
   logic [4:0]  rel_offset;
   logic        is_far;
   logic        is_rel;
   logic        cond_ok;
   logic [9:0]  far_target;

   //////////////////////////////////////////////////////////////////////////

   // Sign-extend the offset to address width; wrap-around of the sum is
   // intended, as code RAM addressing is modulo its size.
   function automatic logic [9:0] scbu_rel_target(
      input logic [9:0] base,
      input logic [4:0] off
   );
      logic [9:0] ext;
      ext = {{(SCBU_ADDR_W - SCBU_OFF_W){off[SCBU_OFF_W - 1]}}, off};
      return base + ext;
   endfunction : scbu_rel_target

   scbu_start_latch u_latch (
      .clk           (clk),
      .rst_n         (rst_n),
      .start_pin     (start_pin),
      .start_clear   (start_clear),
      .start_latched (start_latched)
   );

   //////////////////////////////////////////////////////////////////////////

   assign opcode           = instr_word[SCBU_OPC_MSB:SCBU_OPC_LSB];
   assign start_selector   = instr_word[SCBU_SEL_MSB:SCBU_SEL_LSB];
   assign jump_reg_operand = instr_word[SCBU_JREG_MSB:SCBU_JREG_LSB];
   assign rel_offset       = instr_word[SCBU_OFF_MSB:SCBU_OFF_LSB];
   assign is_far = (opcode == SCBU_OPC_FAR) &&
                   (instr_word[SCBU_PAD_MSB:SCBU_PAD_LSB] == SCBU_FAR_PAD);
   assign is_rel    = (opcode == SCBU_OPC_REL);
   assign is_branch = is_far || is_rel;

   // The selector names an exact combination, so "none" is only met when
   // no start at all is latched.
   assign cond_ok = (start_latched == start_selector);

   always_comb
   begin
      unique case (jump_reg_operand)
         2'h0:    far_target = jump_reg0;
         2'h1:    far_target = jump_reg1;
         2'h2:    far_target = jump_reg2;
         default: far_target = jump_reg3;
      endcase
   end

   always_comb
   begin
      st_nxt       = st_r;
      st_nxt.valid = 1'b0;
      if (instr_valid && is_branch)
      begin
         st_nxt.valid = 1'b1;
         st_nxt.taken = cond_ok;
         if (!cond_ok)
         begin
            st_nxt.next_pc = instr_addr + SCBU_PC_STEP;
         end
         else if (is_far)
         begin
            st_nxt.next_pc = far_target;
         end
         else
         begin
            st_nxt.next_pc = scbu_rel_target(instr_addr, rel_offset);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r <= '{SCBU_PC_RST, 1'b0, 1'b0};
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign program_counter = st_r.next_pc;
   assign pc_valid        = st_r.valid;
   assign branch_taken    = st_r.taken;
endmodule : scbu_branch

// File: verification/scbu_chk_sva.sv
// Port assertions of the start-condition branch unit.
`timescale 1ns/1ns
module scbu_chk (
   input wire logic clk, rst_n, instr_valid, is_branch, pc_valid,
   input wire logic branch_taken,
   input wire logic [15:0] instr_word,
   input wire logic [9:0] instr_addr, program_counter,
   input wire logic [9:0] jump_reg0, jump_reg1, jump_reg2, jump_reg3,
   input wire logic [5:0] start_latched, start_clear
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire [3:0][9:0] jr = {jump_reg3, jump_reg2, jump_reg1, jump_reg0};
   wire [4:0] op = instr_word[15:11];
   wire hit = instr_valid && is_branch && instr_word[10:5] == start_latched;
   wire [9:0] fa = jr[instr_word[1:0]];
   wire [9:0] rt = instr_addr + {{5{instr_word[4]}}, instr_word[4:0]};
   wire [9:0] nx = instr_addr + 10'h001;
   sequence s_go;
      instr_valid && is_branch;
   endsequence
   property p_far;
      hit && op == 5'h07 |=> program_counter == $past(fa);
   endproperty
   a_far: assert property (p_far) else $error("far");
   property p_rel;
      hit && op == 5'h01 |=> program_counter == $past(rt);
   endproperty
   a_rel: assert property (p_rel) else $error("rel");
   property p_nt;
      s_go ##0 !hit |=> !branch_taken && program_counter == $past(nx);
   endproperty
   a_nt: assert property (p_nt) else $error("fall");
   property p_sel;
      s_go |=> pc_valid && branch_taken == $past(hit);
   endproperty
   a_sel: assert property (p_sel) else $error("sel");
   property p_stk;
      start_clear == 6'h00 |=>
         (start_latched | $past(start_latched)) == start_latched;
   endproperty
   a_stk: assert property (p_stk) else $error("latch");
   property p_hold;
      !pc_valid |-> $stable(program_counter);
   endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_ref;
      instr_valid && !is_branch |=> !pc_valid;
   endproperty
   a_ref: assert property (p_ref) else $error("ref");
endmodule : scbu_chk

// File: verification/scbu_branch_tb.sv
// Random and corner stimulus for the start-condition branch unit.
`timescale 1ns/1ns
module scbu_branch_tb;
   logic clk = 0, rst_n = 0, instr_valid = 0;
   logic is_branch, pc_valid, branch_taken;
   logic [15:0] instr_word = 16'h0000, w;
   logic [9:0] instr_addr = 10'h000, program_counter, a, e;
   logic [3:0][9:0] jr = '0;
   logic [5:0] start_pin = 6'h00, start_clear = 6'h00, start_latched, s;
   logic [31:0] lf = 32'hf6194402, r;
   int err_total = 0, comparisons = 0;
   always #20 clk = ~clk;
   scbu_branch scbu_branch_inst (.*, .jump_reg0(jr[0]), .jump_reg1(jr[1]),
      .jump_reg2(jr[2]), .jump_reg3(jr[3]));
   function automatic logic [31:0] rnd();
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      return lf;
   endfunction : rnd
   // Expected next fetch address; wraps modulo the code RAM size.
   function automatic logic [9:0] exp_pc(input logic [15:0] x,
      input logic [9:0] ad, input logic [5:0] l);
      if (x[10:5] !== l)
         return ad + 10'h001;
      if (x[15:11] === 5'h07)
         return jr[x[1:0]];
      return ad + {{5{x[4]}}, x[4:0]};
   endfunction : exp_pc
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("errors %0d checks %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      repeat (3) @(negedge clk);
      rst_n = 1;
      for (int i = 0; i < 40; i++)
      begin
         start_clear = 6'h3f;
         repeat (4) @(negedge clk);
         start_clear = 6'h00;
         s = 6'(rnd());
         start_pin = s;
         jr = 40'({rnd(), rnd()});
         repeat (5) @(negedge clk);
         chk(10'(start_latched), 10'(s));
         // Pins drop first, so only the latched copy can satisfy the jump.
         start_pin = 6'h00;
         r = rnd();
         a = i < 3 ? (i == 1 ? 10'h005 : 10'h3fa) : r[31:22];
         w = {i % 3 ? 5'h01 : 5'h07, (r[6] || i < 3) ? s : r[12:7], r[4:0]};
         if (i == 1 || i == 2)
            w[4:0] = i == 1 ? 5'h10 : 5'h0f;
         if (w[15:11] == 5'h07)
            w[4:2] = 3'h0;
         e = exp_pc(w, a, s);
         instr_word = w;
         instr_addr = a;
         instr_valid = 1;
         #1 chk(10'(is_branch), 10'h001);
         @(negedge clk);
         instr_word = 16'h0000;
         chk(program_counter, e);
         chk(10'(branch_taken), 10'(w[10:5] == s));
         chk(10'(pc_valid), 10'h001);
         @(negedge clk);
         instr_valid = 0;
         chk(10'(pc_valid), 10'h000);
      end
      tally_and_finish();
   end
   initial
   begin
      #100000;
      err_total++;
      tally_and_finish();
   end
endmodule : scbu_branch_tb
bind scbu_branch scbu_chk scbu_chk_inst (.*);
